// *** inc/dsr_pkg.sv ***
/*
 Package for the diagnostic select and report block: register map, field codes,
 conversion constants and the carrier struct between the acquisition engine and this block.
 Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package dsr_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] DSR_A_CTRL    = 8'h00;
	localparam logic [7:0] DSR_A_RESULT  = 8'h04;
	localparam logic [7:0] DSR_A_STATUS  = 8'h08;
	localparam logic [7:0] DSR_A_MASK    = 8'h0C;
	localparam logic [7:0] DSR_A_CELLRES = 8'h10;
	localparam logic [7:0] DSR_A_BLKRES  = 8'h14;
	localparam logic [7:0] DSR_A_AUXRES  = 8'h18;
	localparam logic [7:0] DSR_A_COMPEN  = 8'h1C;

	// ==========================================================
	// Control register fields
	localparam int DSR_F_SEL_LO  = 0;
	localparam int DSR_F_BAL_LO  = 4;
	localparam int DSR_F_TEST    = 8;
	localparam int DSR_F_COMP_LO = 12;

	// ==========================================================
	// Status / alert bit positions
	localparam int DSR_S_HDRM  = 0;
	localparam int DSR_S_TEMP  = 1;
	localparam int DSR_S_BALSW = 2;
	localparam int DSR_S_RXUP  = 3;
	localparam int DSR_S_RXLO  = 4;
	localparam int DSR_S_DONE  = 5;
	localparam int DSR_NSTAT   = 6;

	// ==========================================================
	// Diagnostic select codes
	localparam logic [2:0] DSR_SEL_NONE  = 3'h0;
	localparam logic [2:0] DSR_SEL_ALTERNATE_REFERENCE = 3'h1;
	localparam logic [2:0] DSR_SEL_SUPPLY = 3'h2;
	localparam logic [2:0] DSR_SEL_OFFSET = 3'h3;
	localparam logic [2:0] DSR_SEL_ZERO  = 3'h4;
	localparam logic [2:0] DSR_SEL_FULL  = 3'h5;
	localparam logic [2:0] DSR_SEL_TEMP  = 3'h6;

	// Switch check mode codes
	localparam logic [2:0] DSR_BAL_SHORT = 3'h1;
	localparam logic [2:0] DSR_BAL_OPEN  = 3'h2;
	localparam logic [2:0] DSR_BAL_ODD   = 3'h5;
	localparam logic [2:0] DSR_BAL_EVEN  = 3'h6;

	// Converter sources steered to the diagnostic slot
	localparam logic [2:0] DSR_SRC_ALTERNATE_REFERENCE = 3'h1;
	localparam logic [2:0] DSR_SRC_REF613 = 3'h2;
	localparam logic [2:0] DSR_SRC_SHORT  = 3'h3;
	localparam logic [2:0] DSR_SRC_NEGFS  = 3'h4;
	localparam logic [2:0] DSR_SRC_POSFS  = 3'h5;
	localparam logic [2:0] DSR_SRC_PTAT   = 3'h6;

	// ==========================================================
	// Conversion format
	localparam int          DSR_CODE_W    = 14;
	localparam int          DSR_CODE_LSB  = 2;
	localparam logic [15:0] DSR_ZERO_CODE = 16'h0000;
	localparam logic [15:0] DSR_FULL_CODE = 16'hFFF0;
	localparam logic [15:0] DSR_TEST_PAT  = 16'hA5A4;

	// Receive port mode checks run this long after reset
	localparam int DSR_RXCHK_NS  = 100;
	localparam int DSR_CLK_PS    = 5000;
	localparam int DSR_RXCHK_CYC = (DSR_RXCHK_NS * 1000 + DSR_CLK_PS - 1) / DSR_CLK_PS;

	// Acquisition engine carrier
	typedef struct packed {
		logic        done;
		logic [15:0] result_a_code;
		logic        hdrm_low;
		logic        die_hot;
		logic        bal_fault;
	} dsr_acq_t;

	typedef struct packed {
		logic [2:0] src;
		logic       bipolar;
		logic       thrm_ref;
		logic       comp_mask;
		logic       alternate_multiplexer;
	} dsr_cfg_t;

endpackage

// *** design/dsr_top.sv ***
/*
 Diagnostic select and report logic: APB register file, diagnostic steering to the
 converter, result capture at acquisition end, alert flags and interrupt.
 Assumes the acquisition engine and pin monitors share pclk; receive pin status arrives
 from the pads and is synchronised here.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module dsr_top
	import dsr_pkg::*;
#(
	parameter int RX_CHECK_CYC = DSR_RXCHK_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire dsr_acq_t    acq,
	input  wire logic [1:0]  upper_rx_pin_fault,
	input  wire logic [1:0]  lower_rx_pin_fault,
	output dsr_cfg_t         cfg,
	output logic             converter_path_test,
	output logic             irq
);

	// Pin synchronisers need two cycles before the receive check may fire
	if (RX_CHECK_CYC < 2 || RX_CHECK_CYC > 65535) begin : g_bad_rx_check
		$error("RX_CHECK_CYC out of range");
	end

	// ==========================================================
	// Register state
	logic [2:0]           result_a_measure_select_r;
	logic [2:0]           balance_switch_check_mode_r;
	logic                 test_r;
	logic [2:0]           comp_en_r;
	logic [15:0]          result_a_r;
	logic [15:0]          cell_result_r;
	logic [15:0]          block_voltage_result_r;
	logic [15:0]          aux_input_result_r;
	logic [DSR_NSTAT-1:0] status_r;
	logic [DSR_NSTAT-1:0] mask_r;
	logic [15:0]          rxcnt_r;
	logic                 rxchk_done_r;
	logic [1:0]           up_s1_r;
	logic [1:0]           up_s2_r;
	logic [1:0]           lo_s1_r;
	logic [1:0]           lo_s2_r;

	// ==========================================================
	// Bus decode
	wire        wr_acc  = psel & penable & pwrite;
	wire        rd_acc  = psel & penable & ~pwrite;
	wire        hit_ctl = paddr == DSR_A_CTRL;
	wire        hit_res = paddr == DSR_A_RESULT;
	wire        hit_sts = paddr == DSR_A_STATUS;
	wire        hit_msk = paddr == DSR_A_MASK;
	wire        hit_cel = paddr == DSR_A_CELLRES;
	wire        hit_blk = paddr == DSR_A_BLKRES;
	wire        hit_aux = paddr == DSR_A_AUXRES;
	wire        hit_cmp = paddr == DSR_A_COMPEN;
	wire        mapped  = hit_ctl | hit_res | hit_sts | hit_msk | hit_cel | hit_blk | hit_aux | hit_cmp;
	wire        wr_ctl  = wr_acc & hit_ctl;
	wire        wr_msk  = wr_acc & hit_msk & pstrb[0];
	wire        wr_cmp  = wr_acc & hit_cmp & pstrb[0];
	wire        rd_sts  = rd_acc & hit_sts;
	wire        bal_on  = balance_switch_check_mode_r != 3'h0;

	wire [31:0] ctl_word = {16'h0000, 1'b0, comp_en_r, 3'h0, test_r, 1'b0,
		balance_switch_check_mode_r, 1'b0, result_a_measure_select_r};
	wire [31:0] rd_mux =
		hit_ctl ? ctl_word :
		hit_res ? {16'h0000, result_a_r} :
		hit_sts ? {{(32 - DSR_NSTAT){1'b0}}, status_r} :
		hit_msk ? {{(32 - DSR_NSTAT){1'b0}}, mask_r} :
		hit_cel ? {16'h0000, cell_result_r} :
		hit_blk ? {16'h0000, block_voltage_result_r} :
		hit_aux ? {16'h0000, aux_input_result_r} :
		hit_cmp ? {29'h00000000, comp_en_r} : 32'h00000000;

	// ==========================================================
	// Diagnostic steering
	function automatic dsr_cfg_t steer(input logic [2:0] sel, input logic [2:0] bal);
		dsr_cfg_t c;
		c = '0;
		unique case (sel)
			DSR_SEL_ALTERNATE_REFERENCE: c.src = DSR_SRC_ALTERNATE_REFERENCE;
			DSR_SEL_SUPPLY: begin
				c.src      = DSR_SRC_REF613;
				c.thrm_ref = 1'b1;
			end
			DSR_SEL_OFFSET: begin
				c.src     = DSR_SRC_SHORT;
				c.bipolar = 1'b1;
			end
			DSR_SEL_ZERO: begin
				c.src     = DSR_SRC_NEGFS;
				c.bipolar = 1'b1;
			end
			DSR_SEL_FULL: begin
				c.src     = DSR_SRC_POSFS;
				c.bipolar = 1'b1;
			end
			DSR_SEL_TEMP: c.src = DSR_SRC_PTAT;
			default: c.src = 3'h0;
		endcase
		if (bal != 3'h0) begin
			c.comp_mask = 1'b1;
			c.alternate_multiplexer    = 1'b1;
			if (bal == DSR_BAL_OPEN) begin
				c.bipolar = 1'b1;
			end
		end
		return c;
	endfunction

	wire dsr_cfg_t cfg_nxt = steer(result_a_measure_select_r, balance_switch_check_mode_r);

	// Accepted switch mode codes only
	wire [2:0] bal_wr = pwdata[DSR_F_BAL_LO +: 3];
	wire       bal_ok = bal_wr == 3'h0 || bal_wr == DSR_BAL_SHORT || bal_wr == DSR_BAL_OPEN ||
		bal_wr == DSR_BAL_ODD || bal_wr == DSR_BAL_EVEN;

	// ==========================================================
	// Result capture
	// capture at acquisition end
	wire        capture = acq.done & (result_a_measure_select_r != DSR_SEL_NONE);
	wire [15:0] result_a_val = test_r ? DSR_TEST_PAT : acq.result_a_code;
	wire [15:0] res_fmt  = {result_a_val[15:DSR_CODE_LSB], 2'b00};
	wire [15:0] result_nxt = capture ? res_fmt : result_a_r;

	// ==========================================================
	// Alert events
	logic [DSR_NSTAT-1:0] ev;
	assign ev[DSR_S_HDRM]  = acq.done & acq.hdrm_low;
	assign ev[DSR_S_TEMP]  = acq.done & acq.die_hot & (result_a_measure_select_r == DSR_SEL_TEMP);
	assign ev[DSR_S_BALSW] = acq.done & bal_on & acq.bal_fault;
	assign ev[DSR_S_RXUP]  = (rxcnt_r == 16'(RX_CHECK_CYC)) & ~rxchk_done_r & (up_s2_r != 2'b00);
	assign ev[DSR_S_RXLO]  = (rxcnt_r == 16'(RX_CHECK_CYC)) & ~rxchk_done_r & (lo_s2_r != 2'b00);
	assign ev[DSR_S_DONE]  = acq.done;

	// Set wins over read-clear
	wire [DSR_NSTAT-1:0] status_nxt = ev | (rd_sts ? {DSR_NSTAT{1'b0}} : status_r);

	// ==========================================================
	// Next register values
	wire                 ctl_lo_wr                     = wr_ctl & pstrb[0];
	// Byte 1 counts only when byte 0 is left out of the write
	wire                 ctl_hi_wr                     = wr_ctl & ~pstrb[0] & pstrb[1];
	wire [2:0]           result_a_measure_select_nxt       = ctl_lo_wr ? pwdata[DSR_F_SEL_LO +: 3] : result_a_measure_select_r;
	// Illegal switch mode codes leave the running mode alone
	wire [2:0]           balance_switch_check_mode_nxt = (ctl_lo_wr & bal_ok) ? bal_wr : balance_switch_check_mode_r;
	wire                 test_nxt                      = ctl_hi_wr ? pwdata[DSR_F_TEST] : test_r;
	wire [2:0]           comp_en_nxt                   = wr_cmp ? pwdata[2:0] : comp_en_r;
	wire [DSR_NSTAT-1:0] mask_nxt                      = wr_msk ? pwdata[DSR_NSTAT-1:0] : mask_r;
	wire [15:0]          rxcnt_nxt                     = rxchk_done_r ? rxcnt_r : rxcnt_r + 16'h0001;
	wire                 rxchk_done_nxt                = rxchk_done_r | (rxcnt_r == 16'(RX_CHECK_CYC));
	wire                 test_acq                      = acq.done & test_r;
	wire [15:0]          cell_result_nxt               = test_acq ? DSR_TEST_PAT : cell_result_r;
	wire [15:0]          block_voltage_result_nxt      = test_acq ? DSR_TEST_PAT : block_voltage_result_r;
	wire [15:0]          aux_input_result_nxt          = test_acq ? DSR_TEST_PAT : aux_input_result_r;
	wire                 setup_cyc                     = psel & ~penable;
	wire                 pready_nxt                    = setup_cyc;
	wire                 pslverr_nxt                   = setup_cyc & ~mapped;
	// Read data is latched in setup and held until the next read
	wire [31:0]          prdata_nxt                    = (setup_cyc & ~pwrite) ? rd_mux : prdata;
	wire                 irq_nxt                       = |(status_nxt & mask_r);

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_s1_r <= 2'b00;
			up_s2_r <= 2'b00;
			lo_s1_r <= 2'b00;
			lo_s2_r <= 2'b00;
		end else begin
			up_s1_r <= upper_rx_pin_fault;
			up_s2_r <= up_s1_r;
			lo_s1_r <= lower_rx_pin_fault;
			lo_s2_r <= lo_s1_r;
		end
	end

	// ==========================================================
	// Receive pin check timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxcnt_r <= 16'h0000;
		end else begin
			rxcnt_r <= rxcnt_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxchk_done_r <= 1'b0;
		end else begin
			rxchk_done_r <= rxchk_done_nxt;
		end
	end

	// ==========================================================
	// Control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_a_measure_select_r <= 3'h0;
		end else begin
			result_a_measure_select_r <= result_a_measure_select_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			balance_switch_check_mode_r <= 3'h0;
		end else begin
			balance_switch_check_mode_r <= balance_switch_check_mode_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			test_r <= 1'b0;
		end else begin
			test_r <= test_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_en_r <= 3'h7;
		end else begin
			comp_en_r <= comp_en_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= {DSR_NSTAT{1'b0}};
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ==========================================================
	// Results and status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_a_r <= 16'h0000;
		end else begin
			result_a_r <= result_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= {DSR_NSTAT{1'b0}};
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_result_r <= 16'h0000;
		end else begin
			cell_result_r <= cell_result_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_voltage_result_r <= 16'h0000;
		end else begin
			block_voltage_result_r <= block_voltage_result_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_input_result_r <= 16'h0000;
		end else begin
			aux_input_result_r <= aux_input_result_nxt;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else begin
			prdata <= prdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= pready_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= '0;
		end else begin
			cfg <= cfg_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_path_test <= 1'b0;
		end else begin
			converter_path_test <= test_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_nxt;
		end
	end

endmodule

// *** dv/dsr_chk_asserts.sv ***
/*
 Port checker for dsr_top.
 Assumes the bind below attaches it to every dsr_top.
*/
`timescale 1ns/1ps
module dsr_chk
	import dsr_pkg::*;
#(
	parameter int RX_CHECK_CYC = DSR_RXCHK_CYC
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire dsr_acq_t    acq,
	input wire dsr_cfg_t    cfg
);
	wire acc  = psel && penable && pready;
	wire wr_c = acc && pwrite && paddr == DSR_A_CTRL && pstrb[0];

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// Assertions
	setup_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	unmapped_err_a: assert property (acc && paddr > 8'h1C |-> pslverr)
		else $error("no error on unmapped");
	result_lsb_a: assert property (acc && !pwrite && paddr == DSR_A_RESULT |-> prdata[1:0] == 2'h0)
		else $error("result low bits set");
	alt_source_a: assert property (wr_c && pwdata[2:0] == DSR_SEL_ALTERNATE_REFERENCE |-> ##[1:2] cfg.src == DSR_SRC_ALTERNATE_REFERENCE)
		else $error("alternate source missing");
	supply_ref_a: assert property (wr_c && pwdata[2:0] == DSR_SEL_SUPPLY |->
		##[1:2] cfg.src == DSR_SRC_REF613 && cfg.thrm_ref) else $error("supply check setup wrong");
	zero_bipolar_a: assert property (wr_c && pwdata[2:0] == DSR_SEL_ZERO |->
		##[1:2] cfg.src == DSR_SRC_NEGFS && cfg.bipolar) else $error("zero scale setup wrong");
	full_bipolar_a: assert property (wr_c && pwdata[2:0] == DSR_SEL_FULL |->
		##[1:2] cfg.src == DSR_SRC_POSFS && cfg.bipolar) else $error("full scale setup wrong");
	bal_mask_a: assert property (wr_c && pwdata[6:4] == DSR_BAL_ODD |-> ##[1:2] cfg.comp_mask)
		else $error("compare not masked");
	bal_restore_a: assert property (wr_c && pwdata[6:4] == 3'h0 |-> ##[1:2] !cfg.comp_mask)
		else $error("compare not restored");

	cover property (wr_c);
	cover property (acq.done);
	cover property (acc && pslverr);
endmodule

bind dsr_top dsr_chk #(.RX_CHECK_CYC(RX_CHECK_CYC)) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .acq(acq), .cfg(cfg)
);

// *** dv/dsr_acq_model.sv ***
/*
 Acquisition engine model: one done pulse four cycles after go.
 Assumes go is a one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
module dsr_acq_model
	import dsr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        go,
	input  wire logic [15:0] code,
	input  wire logic [2:0]  flags,
	input  wire dsr_cfg_t    cfg,
	output dsr_acq_t         acq
);
	logic [2:0]  cnt_r = 3'h0;
	logic [15:0] val;

	assign val = cfg.src == DSR_SRC_NEGFS ? DSR_ZERO_CODE : cfg.src == DSR_SRC_POSFS ? DSR_FULL_CODE : code;
	assign acq = cnt_r == 3'h1 ? {1'b1, val, flags} : {1'b0, ~val, ~flags};

	always_ff @(posedge pclk) begin
		cnt_r <= go ? 3'h4 : cnt_r - 3'(cnt_r != 3'h0);
	end
endmodule

// *** dv/tb_diagnostic_select_report.sv ***
/*
 Testbench for dsr_top with an acquisition engine model.
 Assumes the slave answers every transfer; the watchdog ends any hang.
*/
`timescale 1ns/1ps
module tb_diagnostic_select_report
	import dsr_pkg::*;
;
	localparam logic [13:0] C14 = 14'h048D;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'h0;
	logic        pready, pslverr, irq, cpt, er;
	logic [1:0]  up_f = 2'h1, lo_f = 2'h2;
	logic [15:0] code = 16'h0;
	logic [2:0]  flg = 3'h0;
	dsr_acq_t    acq;
	dsr_cfg_t    cfg;
	int          fails = 0, comparisons = 0;

	dsr_top #(.RX_CHECK_CYC(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acq(acq), .upper_rx_pin_fault(up_f), .lower_rx_pin_fault(lo_f), .cfg(cfg),
		.converter_path_test(cpt), .irq(irq));
	dsr_acq_model far (.pclk(pclk), .go(go), .code(code), .flags(flg), .cfg(cfg), .acq(acq));

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task acquire(input logic [15:0] c, input logic [2:0] f);
		@(posedge pclk);
		code <= c;
		flg <= f;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		do begin
			@(posedge pclk);
		end while (acq.done !== 1'b1);
		@(posedge pclk);
	endtask

	task t_reset;
		repeat (6) @(posedge pclk);
		apb(0, DSR_A_CTRL, 0, 4'h0);
		chk(rd, 32'h7000);
		apb(0, DSR_A_STATUS, 0, 4'h0);
		chk(rd, 32'h18);
		apb(0, DSR_A_STATUS, 0, 4'h0);
		chk(rd, 32'h0);
		$display("reset test done");
	endtask

	task t_unmapped;
		apb(0, 8'h20, 0, 4'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		apb(1, 8'h24, 32'hFFFF, 4'hF);
		chk(er, 1);
		$display("unmapped test done");
	endtask

	task t_result_a;
		for (int s = 1; s < 7; s++) begin
			apb(1, DSR_A_CTRL, 32'(s), 4'h1);
			acquire({C14, 2'h3}, 3'h3);
			apb(0, DSR_A_RESULT, 0, 4'h0);
			chk(rd, s == 4 ? DSR_ZERO_CODE : s == 5 ? DSR_FULL_CODE : {C14, 2'h0});
			chk(cfg.bipolar, 32'(s >= 3 && s <= 5));
			if (s == 3) begin
				chk(cfg.src, DSR_SRC_SHORT);
			end
		end
		chk(cfg.src, DSR_SRC_PTAT);
		apb(0, DSR_A_STATUS, 0, 4'h0);
		chk(rd, 32'h22);
		chk(irq, 0);
		$display("select test done");
	endtask

	task t_irq;
		apb(1, DSR_A_MASK, 32'h1, 4'hF);
		acquire(16'h0100, 3'h4);
		chk(irq, 1);
		apb(0, DSR_A_STATUS, 0, 4'h0);
		chk(rd, 32'h21);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		$display("interrupt test done");
	endtask

	task t_test;
		apb(1, DSR_A_CTRL, 32'h100, 4'h2);
		repeat (2) @(posedge pclk);
		chk(cpt, 1);
		acquire(16'h0100, 3'h0);
		apb(0, DSR_A_RESULT, 0, 4'h0);
		chk(rd, DSR_TEST_PAT);
		for (int a = 16; a < 28; a += 4) begin
			apb(0, 8'(a), 0, 4'h0);
			chk(rd, DSR_TEST_PAT);
		end
		apb(1, DSR_A_CTRL, 32'h0, 4'h2);
		$display("path test done");
	endtask

	task t_none;
		apb(1, DSR_A_CTRL, 32'h0, 4'h1);
		acquire(16'h2220, 3'h0);
		apb(0, DSR_A_RESULT, 0, 4'h0);
		chk(rd, DSR_TEST_PAT);
		$display("no select test done");
	endtask

	task t_bal;
		for (int i = 0; i < 4; i++) begin
			apb(1, DSR_A_CTRL, 32'(i < 2 ? i + 1 : i + 3) << 4, 4'h1);
			apb(1, DSR_A_CTRL, 32'h30, 4'h1);
			acquire(16'h0100, 3'h1);
			chk(cfg.comp_mask, 1);
			chk(cfg.alternate_multiplexer, 1);
			apb(0, DSR_A_STATUS, 0, 4'h0);
			chk(rd, 32'h24);
		end
		apb(1, DSR_A_CTRL, 32'h0, 4'h1);
		repeat (3) @(posedge pclk);
		chk(cfg.comp_mask, 0);
		chk(cfg.alternate_multiplexer, 0);
		$display("switch test done");
	endtask

	task complete_run;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#30000;
		fails++;
		complete_run;
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_unmapped;
		t_result_a;
		t_irq;
		t_test;
		t_none;
		t_bal;
		complete_run;
	end
endmodule
